// ### rtl/fpsq_pkg.sv
// Shared constants for the bus front panel sequencer.
package fpsq_pkg;
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_PER_US     = CLK_HZ / 1_000_000;
  // Debounce one-shot period, about one millisecond.
  localparam int DEBOUNCE_US    = 1000;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_PER_US;
  // Memory write pulse width, about 0.1 ms.
  localparam int MWRITE_US      = 100;
  localparam int MWRITE_CYC     = MWRITE_US * CLK_PER_US;
  // Driver turn-on delay after the single-step line falls (least time, rounded up).
  localparam int DRV_DLY_NS     = 100;
  localparam int DRV_DLY_CYC    = (DRV_DLY_NS * CLK_PER_US + 999) / 1000;
  // Further delay from driver on to the write pulse, for data set-up.
  localparam int DLY_TOP        = 2 * DRV_DLY_CYC;
  localparam logic [7:0] JUMP_OPCODE = 8'hC3;
  localparam logic [7:0] NOP_OPCODE  = 8'h00;
  localparam logic [7:0] PORT_ADDR   = 8'hFF;
  // Function request bit positions.
  localparam int REQ_EXAM       = 0;
  localparam int REQ_EXNEXT     = 1;
  localparam int REQ_DEP        = 2;
  localparam int REQ_DEPNEXT    = 3;
  localparam int REQ_STEP       = 4;
  typedef enum logic [2:0] {
    FPSQ_IDLE   = 3'h0,
    FPSQ_EXNEXT = 3'h1,
    FPSQ_EXAM   = 3'h2,
    FPSQ_DEP    = 3'h3,
    FPSQ_STEP   = 3'h4
  } fpsq_mode_type;
endpackage

// ### rtl/fpsq_oneshot.sv
// Retriggerable-free debounce one-shot with busy level and expiry pulse.
`timescale 1ns/100ps
`default_nettype none
module fpsq_oneshot #(
  parameter int CYCLES = 50000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trig,
  output var  logic busy,
  output var  logic expire
);
  localparam int CW = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          busy;
    logic          expire;
  } fpsq_shot_type;
  fpsq_shot_type st_q, st_d;

  if (CYCLES < 2) begin : g_chk
    $error("fpsq_oneshot: CYCLES must be at least 2");
  end

  // A trigger while running is ignored, like a non-retriggerable one-shot.
  always_comb begin
    st_d        = st_q;
    st_d.expire = 1'b0;
    if (!st_q.busy && trig) begin
      st_d.cnt  = CW'(CYCLES - 1);
      st_d.busy = 1'b1;
    end else if (st_q.busy) begin
      if (st_q.cnt == '0) begin
        st_d.busy   = 1'b0;
        st_d.expire = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy   = st_q.busy;
  assign expire = st_q.expire;
endmodule
`default_nettype wire

// ### rtl/fpsq_top.sv
// Front panel sequencer: examine, combined functions, repeats, breakpoints, bus-valid and port FF.
`timescale 1ns/100ps
`default_nettype none
module fpsq_top
  import fpsq_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int MWRITE_CYCLES   = MWRITE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psync,
  input  wire logic        dbin,
  input  wire logic        pwr_n,
  input  wire logic        sout,
  input  wire logic        sinp,
  input  wire logic        prdy,
  input  wire logic        phi2,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_in,
  input  wire logic [15:0] panel_sw,
  input  wire logic [4:0]  func_req,
  input  wire logic        repeat_function_mode,
  input  wire logic        endless_noop_mode,
  input  wire logic        repeated_deposit_mode,
  input  wire logic        stop_mode,
  input  wire logic        run_mode,
  input  wire logic [3:0]  bp_select,
  input  wire logic        bp_enable,
  input  wire logic        bp_latched,
  input  wire logic        bp_status,
  input  wire logic        bp_ext,
  input  wire logic        bv_clk_falling,
  input  wire logic        bv_clip_end,
  input  wire logic        bv_use_clipped,
  output logic             ss_n,
  output logic             xrdy,
  output logic [7:0]       data_out,
  output logic             data_oe_n,
  output logic             mwrite,
  output logic [7:0]       out_port,
  output logic             bus_valid_flag,
  output logic             bus_valid_out
);
  localparam int SW = 68;
  // Synchroniser reset image with the write strobe idle high, so no false bus-valid follows reset.
  localparam logic [SW-1:0] SYNC_IDLE = {2'b00, 1'b1, 65'h0};

  if (MWRITE_CYCLES < 1 || MWRITE_CYCLES > 65535) begin : g_chk
    $error("fpsq_top: MWRITE_CYCLES out of range");
  end

  typedef struct packed {
    logic [SW-1:0]  s1;
    logic [SW-1:0]  s2;
    fpsq_mode_type  mode;
    logic [1:0]     stage;
    logic           dep_armed;
    logic [4:0]     req_prev;
    logic [3:0]     dly;
    logic [15:0]    mw;
    logic           mw_done;
    logic           bp_latch;
    logic           bv;
    logic           bv_dly;
    logic           phi2_prev;
    logic           psync_prev;
    logic           pcond;
    logic [7:0]     pbuf;
    logic [7:0]     out_port;
    logic           ss_n;
    logic           xrdy;
    logic [7:0]     dout;
    logic           doe_n;
    logic           mwrite;
    logic           bvo;
  } fpsq_state_type;

  fpsq_state_type st_q, st_d;
  logic db_trig;
  logic db_busy;
  logic db_expire;

  // Synchronised pin view, unpacked from the second stage only.
  logic psync_s, dbin_s, pwr_n_s, sout_s, sinp_s, prdy_s, phi2_s, stop_s, run_s;
  logic rep_s, noop_s, rdep_s, bp_en_s, bp_lat_s, bp_st_s, bp_ex_s, bvf_s, bvce_s, bvuc_s;
  logic [15:0] addr_s, sw_s;
  logic [7:0]  din_s;
  logic [4:0]  req_s;
  logic [3:0]  bpsel_s;
  assign {psync_s, dbin_s, pwr_n_s, sout_s, sinp_s, prdy_s, phi2_s, addr_s, din_s, sw_s, req_s,
          rep_s, noop_s, rdep_s, stop_s, run_s, bp_st_s, bp_ex_s, bpsel_s, bp_en_s, bp_lat_s,
          bvf_s, bvce_s, bvuc_s} = st_q.s2;

  // debounce one-shot shared by all panel functions.
  fpsq_oneshot #(.CYCLES(DEBOUNCE_CYCLES)) u_debounce (
    .clk    (clk),
    .rst    (rst),
    .trig   (db_trig),
    .busy   (db_busy),
    .expire (db_expire)
  );

  always_comb begin
    logic [4:0] edge_req, fire;
    logic       psync_rise, phi2_rise, bv_edge, can_start, rdep_start, match, bp_stop;
    logic       port_in, port_cond, drv_ok, active_ss;
    edge_req   = '0;
    fire       = '0;
    psync_rise = 1'b0;
    phi2_rise  = 1'b0;
    bv_edge    = 1'b0;
    can_start  = 1'b0;
    rdep_start = 1'b0;
    match      = 1'b0;
    bp_stop    = 1'b0;
    port_in    = 1'b0;
    port_cond  = 1'b0;
    drv_ok     = 1'b0;
    active_ss  = 1'b0;
    st_d       = st_q;
    db_trig    = 1'b0;
    // Two-stage synchroniser for every pin.
    st_d.s1 = {psync, dbin, pwr_n, sout, sinp, prdy, phi2, addr, data_in, panel_sw, func_req,
               repeat_function_mode, endless_noop_mode, repeated_deposit_mode, stop_mode,
               run_mode, bp_status, bp_ext, bp_select, bp_enable, bp_latched,
               bv_clk_falling, bv_clip_end, bv_use_clipped};
    st_d.s2 = st_q.s1;
    st_d.req_prev   = req_s;
    st_d.psync_prev = psync_s;
    st_d.phi2_prev  = phi2_s;
    psync_rise = psync_s && !st_q.psync_prev;
    phi2_rise  = phi2_s && !st_q.phi2_prev;
    bv_edge    = bvf_s ? (!phi2_s && st_q.phi2_prev) : phi2_rise;
    edge_req   = req_s & ~st_q.req_prev;
    // repeat mode turns a held switch into a continuous trigger.
    fire = rep_s ? req_s : edge_req;
    // functions start only when stopped, idle and debounce expired.
    can_start = (st_q.mode == FPSQ_IDLE) && !db_busy && stop_s && !noop_s;
    // repeated deposit restarts on the bus clock once debounce falls.
    rdep_start = can_start && rdep_s && phi2_rise && (fire == '0);
    if (can_start && fire[REQ_EXAM]) begin
      st_d.mode  = FPSQ_EXAM;
      st_d.stage = 2'h0;
    end else if (can_start && (fire[REQ_EXNEXT] || fire[REQ_DEPNEXT])) begin
      // combined function arms deposit together with examine-next.
      st_d.mode      = FPSQ_EXNEXT;
      st_d.dep_armed = fire[REQ_DEPNEXT] && !fire[REQ_EXNEXT];
    end else if (can_start && fire[REQ_STEP] && !fire[REQ_DEP]) begin
      st_d.mode = FPSQ_STEP;
    end else if ((can_start && fire[REQ_DEP]) || rdep_start) begin
      // the bus clock gate feeds both debounce and deposit control.
      st_d.mode      = FPSQ_DEP;
      st_d.dep_armed = 1'b0;
      db_trig        = 1'b1;
    end else begin
      case (st_q.mode)
        FPSQ_EXAM: begin
          if (psync_rise) begin
            // each PSYNC shifts the driven byte one step.
            if (st_q.stage == 2'h0) begin
              db_trig = 1'b1;
            end
            if (st_q.stage == 2'h2) begin
              // fourth-cycle PSYNC ends examine and stops the processor.
              st_d.mode = FPSQ_IDLE;
            end
            st_d.stage = st_q.stage + 2'h1;
          end
        end
        FPSQ_EXNEXT: begin
          if (psync_rise) begin
            db_trig   = 1'b1;
            st_d.mode = st_q.dep_armed ? FPSQ_DEP : FPSQ_IDLE;
          end
        end
        FPSQ_STEP: begin
          if (psync_rise) begin
            db_trig   = 1'b1;
            st_d.mode = FPSQ_IDLE;
          end
        end
        FPSQ_DEP: begin
          // combined deposit waits for debounce fired and DBIN high.
          if (st_q.dep_armed && db_busy && dbin_s) begin
            st_d.dep_armed = 1'b0;
          end
          if (db_expire) begin
            st_d.mode      = FPSQ_IDLE;
            st_d.dep_armed = 1'b0;
          end
        end
        default: st_d.mode = FPSQ_IDLE;
      endcase
    end
    // driver turn-on delay counts from the fall of single-step.
    active_ss = (st_d.mode == FPSQ_EXNEXT) || (st_d.mode == FPSQ_EXAM) || noop_s ||
                ((st_d.mode == FPSQ_DEP) && !st_d.dep_armed);
    if (!active_ss) begin
      st_d.dly = '0;
    end else if (st_q.dly != 4'(DLY_TOP)) begin
      st_d.dly = st_q.dly + 4'h1;
    end
    drv_ok = (st_q.dly >= 4'(DRV_DLY_CYC)) && active_ss;
    // Write pulse fires once per deposit, after data has been set up.
    if (st_d.mode != FPSQ_DEP) begin
      st_d.mw_done = 1'b0;
    end
    if (active_ss && (st_d.mode == FPSQ_DEP) && !st_q.mw_done && (st_q.dly == 4'(DLY_TOP - 1))) begin
      st_d.mw      = 16'(MWRITE_CYCLES);
      st_d.mw_done = 1'b1;
    end else if (st_q.mw != '0) begin
      st_d.mw = st_q.mw - 16'h1;
    end
    st_d.mwrite = (st_d.mw != '0);
    // selected conditions must all hold; an unselected one passes.
    match = (bpsel_s != '0) && (!bpsel_s[0] || (addr_s == sw_s)) &&
            (!bpsel_s[1] || (din_s == sw_s[7:0])) && (!bpsel_s[2] || bp_st_s) && (!bpsel_s[3] || bp_ex_s);
    // deselect or any panel function start drops the held stop.
    if (!bp_en_s || (fire != '0) || (st_q.mode != FPSQ_IDLE)) begin
      st_d.bp_latch = 1'b0;
    end else if (match && bp_lat_s) begin
      st_d.bp_latch = 1'b1;
    end
    bp_stop = bp_en_s && (match || (bp_lat_s && st_q.bp_latch));
    // XRDY high lets the processor run; low holds it in wait.
    st_d.xrdy = (run_s || noop_s || (st_d.mode == FPSQ_EXAM) || (st_d.mode == FPSQ_EXNEXT) ||
                 (st_d.mode == FPSQ_STEP)) && !bp_stop;
    // SS low lets the panel own the data bus.
    st_d.ss_n = !active_ss;
    // port FF input returns the upper switch byte.
    port_in    = dbin_s && sinp_s && (addr_s[7:0] == PORT_ADDR);
    st_d.doe_n = 1'b1;
    st_d.dout  = st_q.dout;
    if (port_in) begin
      st_d.doe_n = 1'b0;
      st_d.dout  = sw_s[15:8];
    end else if (drv_ok && (st_d.mode == FPSQ_EXAM)) begin
      // jump opcode, low address byte, high address byte.
      st_d.doe_n = 1'b0;
      st_d.dout  = (st_d.stage == 2'h0) ? JUMP_OPCODE : (st_d.stage == 2'h1) ? sw_s[7:0] : sw_s[15:8];
    end else if (drv_ok && (st_d.mode == FPSQ_DEP)) begin
      st_d.doe_n = 1'b0;
      st_d.dout  = sw_s[7:0];
    end else if (drv_ok && dbin_s && (noop_s || (st_d.mode == FPSQ_EXNEXT))) begin
      // all-zero opcode on every read keeps the no-ops flowing.
      st_d.doe_n = 1'b0;
      st_d.dout  = NOP_OPCODE;
    end
    // write strobe overrides the DBIN clear.
    if (!pwr_n_s) begin
      st_d.bv = 1'b1;
    end else if (!dbin_s) begin
      // strobe gone and DBIN low clears at once.
      st_d.bv = 1'b0;
    end else if (bv_edge) begin
      // sample PRDY on the jumpered edge.
      st_d.bv = prdy_s;
    end
    // clipped form trims the start or keeps only the start.
    if (!st_q.bv) begin
      st_d.bv_dly = 1'b0;
    end else if (bv_edge) begin
      st_d.bv_dly = 1'b1;
    end
    st_d.bvo = bvuc_s ? (st_d.bv && (bvce_s ? !st_d.bv_dly : st_d.bv_dly)) : st_d.bv;
    // port FF output latches on the trailing end of the write.
    port_cond  = !pwr_n_s && sout_s && (addr_s[7:0] == PORT_ADDR);
    st_d.pcond = port_cond;
    if (port_cond) begin
      st_d.pbuf = din_s;
    end
    if (st_q.pcond && !port_cond) begin
      st_d.out_port = st_q.pbuf;
    end
  end

  // Reset to a stopped, idle panel with all drivers off.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q       <= '0;
      st_q.s1    <= SYNC_IDLE;
      st_q.s2    <= SYNC_IDLE;
      st_q.mode  <= FPSQ_IDLE;
      st_q.ss_n  <= 1'b1;
      st_q.doe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign ss_n           = st_q.ss_n;
  assign xrdy           = st_q.xrdy;
  assign data_out       = st_q.dout;
  assign data_oe_n      = st_q.doe_n;
  assign mwrite         = st_q.mwrite;
  assign out_port       = st_q.out_port;
  assign bus_valid_flag = st_q.bv;
  assign bus_valid_out  = st_q.bvo;

  // Helper views for the checks below.
  logic port_in_now;
  logic bp_stop_now;
  assign port_in_now = dbin_s && sinp_s && (addr_s[7:0] == PORT_ADDR);
  assign bp_stop_now = bp_en_s && (bpsel_s != '0) && (!bpsel_s[0] || (addr_s == sw_s)) &&
                       (!bpsel_s[1] || (din_s == sw_s[7:0])) && (!bpsel_s[2] || bp_st_s) &&
                       (!bpsel_s[3] || bp_ex_s);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence exam_last_s;
    st_q.mode == FPSQ_EXAM && st_q.stage == 2'h2 && psync_s && !st_q.psync_prev;
  endsequence
  sequence panel_off_s;
    st_q.ss_n && !st_q.xrdy && st_q.doe_n;
  endsequence

  exam_stop_only_a: assert property ($rose(st_q.mode == FPSQ_EXAM) |-> $past(stop_s))
    else $error("examine started while running");
  exam_start_a: assert property ($rose(st_q.mode == FPSQ_EXAM) |-> !st_q.ss_n && st_q.doe_n)
    else $error("examine start levels wrong");
  drv_delay_a: assert property ($fell(st_q.ss_n) && !port_in_now |-> st_q.doe_n[*4])
    else $error("driver enabled too early");
  exam_hold_a: assert property (st_q.mode == FPSQ_EXAM && !noop_s |-> !st_q.ss_n)
    else $error("single-step rose during examine");
  exam_end_a: assert property ((exam_last_s and (!run_s && !noop_s && !port_in_now)) |=> panel_off_s)
    else $error("examine did not stop at fourth cycle");
  noop_a: assert property (noop_s && !bp_stop_now && !st_q.bp_latch |=> !st_q.ss_n && st_q.xrdy)
    else $error("no-op mode levels wrong");
  bv_set_a: assert property (!pwr_n_s |=> st_q.bv)
    else $error("bus-valid not forced by write strobe");
  bv_clear_a: assert property (pwr_n_s && !dbin_s |=> !st_q.bv)
    else $error("bus-valid not cleared");
  port_in_a: assert property (port_in_now |=> !st_q.doe_n && st_q.dout == $past(sw_s[15:8]))
    else $error("port input byte not driven");
  bp_stop_a: assert property (bp_stop_now |=> !st_q.xrdy)
    else $error("breakpoint did not stop processor");
endmodule
`default_nettype wire

// ### test/fpsq_cpu_model.sv
// Behavioural processor board that runs bus cycles against the front panel.
`timescale 1ns/100ps
`default_nettype none
module fpsq_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       xrdy,
  input  wire logic       ss_n,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  output logic            psync,
  output logic            dbin,
  output wire logic [7:0] bus
);
  logic [7:0] got_q [$];
  logic [7:0] last_q;
  logic [1:0] ph_q;
  int         cnt_q;

  // buffers off
  // Memory answers only while single-step is high; an undriven bus flips every cycle.
  assign bus = !data_oe_n ? data_out : (ss_n ? 8'h76 : ~last_q);

  // ready gates cycles
  // Parked in a read wait state; ready lets the read finish, then sync opens the next cycle.
  // Ready is looked at late in the cycle, so a slow stop request still lands in time.
  always @(posedge clk) begin
    last_q <= bus;
    cnt_q  <= cnt_q + 1;
    if (rst) begin
      ph_q  <= 2'h0;
      cnt_q <= 99;
      psync <= 1'b0;
      dbin  <= 1'b1;
    end else if (ph_q == 2'h0 && cnt_q >= 6 && xrdy) begin
      ph_q  <= 2'h1;
      cnt_q <= 0;
    end else if (ph_q == 2'h1 && cnt_q == 10) begin
      got_q.push_back(bus);
      ph_q  <= 2'h2;
      cnt_q <= 0;
      dbin  <= 1'b0;
    end else if (ph_q == 2'h2) begin
      psync <= (cnt_q == 2 || cnt_q == 3);
      if (cnt_q == 5) begin
        ph_q  <= 2'h0;
        cnt_q <= 0;
        dbin  <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/fpsq_top_tb_top.sv
// Self-checking bench for the front panel sequencer against a processor board model.
`timescale 1ns/100ps
`default_nettype none
module fpsq_top_tb_top import fpsq_pkg::*; ;
  localparam int DEB = 200;
  localparam int MWR = 8;
  logic        clk = 1'b0, rst = 1'b1, tb_own = 1'b0, tb_dbin = 1'b0, pwr_n = 1'b1;
  logic        sout = 1'b0, sinp = 1'b0, prdy = 1'b0, stop_mode = 1'b1, run_mode = 1'b0;
  logic        repeat_function_mode = 1'b0, endless_noop_mode = 1'b0, repeated_deposit_mode = 1'b0;
  logic        bp_enable = 1'b0, bp_latched = 1'b0, bp_status = 1'b0, bp_ext = 1'b0;
  logic        bv_clk_falling = 1'b0, bv_clip_end = 1'b0, bv_use_clipped = 1'b0;
  logic [1:0]  phi_cnt = 2'h0;
  logic [3:0]  bp_select = 4'h0;
  logic [4:0]  func_req = 5'h00;
  logic [7:0]  tb_bus = 8'h00;
  logic [15:0] addr = 16'h0000, panel_sw = 16'h3C96;
  logic [7:0]  exp_q [$];
  wire  logic  psync, dbin, phi2, cpu_psync, cpu_dbin;
  wire  logic [7:0] data_in, cpu_bus;
  logic        ss_n, xrdy, data_oe_n, mwrite, bus_valid_flag, bus_valid_out, last_mw;
  logic [7:0]  data_out, out_port;
  int          err_total = 0, total_checks = 0, n, w, m, k;

  // Free-running bus clock at a quarter of the system clock; the bench may take the bus over.
  always #10 clk = ~clk;
  always @(posedge clk) phi_cnt <= phi_cnt + 2'h1;
  assign phi2    = phi_cnt[1];
  assign psync   = tb_own ? 1'b0 : cpu_psync;
  assign dbin    = tb_own ? tb_dbin : cpu_dbin;
  assign data_in = tb_own ? tb_bus : cpu_bus;

  fpsq_top #(.DEBOUNCE_CYCLES(DEB), .MWRITE_CYCLES(MWR)) fpsq_top_i (
    .clk, .rst, .psync, .dbin, .pwr_n, .sout, .sinp, .prdy, .phi2, .addr, .data_in, .panel_sw,
    .func_req, .repeat_function_mode, .endless_noop_mode, .repeated_deposit_mode, .stop_mode,
    .run_mode, .bp_select, .bp_enable, .bp_latched, .bp_status, .bp_ext, .bv_clk_falling,
    .bv_clip_end, .bv_use_clipped, .ss_n, .xrdy, .data_out, .data_oe_n, .mwrite, .out_port,
    .bus_valid_flag, .bus_valid_out);
  fpsq_cpu_model fpsq_cpu_model_i (.clk, .rst, .xrdy, .ss_n, .data_out, .data_oe_n,
    .psync(cpu_psync), .dbin(cpu_dbin), .bus(cpu_bus));

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // Drives land on the edge; looks happen once that edge has settled.
  task automatic step(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic look(input int c);
    step(c);
    #1;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return ss_n;
      1: return xrdy;
      2: return data_oe_n;
      3: return mwrite;
      default: return bus_valid_flag;
    endcase
  endfunction

  // Bounded wait on one output; running out ends the run as a mismatch.
  task automatic wait_sig(input int s, input logic v, input int lim);
    int c;
    c = 0;
    #1;
    while (pick(s) !== v && c < lim) begin
      look(1);
      c++;
    end
    chk($sformatf("wait on output %0d", s), {7'h00, v}, {7'h00, pick(s)});
    if (pick(s) !== v) tally_and_finish();
  endtask

  task automatic chk_bytes(input string what);
    chk({what, " count"}, 8'h01, 8'(fpsq_cpu_model_i.got_q.size() >= exp_q.size()));
    foreach (exp_q[i]) if (i < fpsq_cpu_model_i.got_q.size()) chk(what, exp_q[i], fpsq_cpu_model_i.got_q[i]);
  endtask

  initial begin
    step(2);
    rst <= 1'b0;
    look(1);
    chk("reset ss_n xrdy oe_n", 8'h05, {5'h00, ss_n, xrdy, data_oe_n});
    // Examine: jump opcode, low switches, high switches, then stop in the next fetch.
    step(3);
    func_req <= 5'h01;
    wait_sig(0, 1'b0, 10);
    chk("examine start xrdy oe_n", 8'h03, {6'h00, xrdy, data_oe_n});
    step(1);
    func_req <= 5'h00;
    wait_sig(2, 1'b0, 10);
    wait_sig(1, 1'b0, 300);
    chk("examine end", 8'h05, {5'h00, ss_n, xrdy, data_oe_n});
    look(30);
    chk("examine cycles", 8'h03, 8'(fpsq_cpu_model_i.got_q.size()));
    exp_q = {JUMP_OPCODE, panel_sw[7:0], panel_sw[15:8]};
    chk_bytes("examine byte");
    step(2 * DEB);
    stop_mode <= 1'b0;
    func_req  <= 5'h01;
    look(30);
    chk("examine while running", 8'h01, {7'h00, ss_n});
    step(1);
    func_req  <= 5'h00;
    stop_mode <= 1'b1;
    step(2 * DEB);
    // Endless no-operation mode.
    fpsq_cpu_model_i.got_q.delete();
    endless_noop_mode <= 1'b1;
    look(150);
    chk("noop ss_n xrdy", 8'h01, {6'h00, ss_n, xrdy});
    exp_q = {NOP_OPCODE, NOP_OPCODE, NOP_OPCODE};
    chk_bytes("noop byte");
    step(1);
    endless_noop_mode <= 1'b0;
    wait_sig(0, 1'b1, 20);
    step(2 * DEB);
    // Combined function: one examine-next byte must be taken before the write pulse.
    fpsq_cpu_model_i.got_q.delete();
    func_req <= 5'h08;
    wait_sig(0, 1'b0, 10);
    step(1);
    func_req <= 5'h00;
    wait_sig(3, 1'b1, 200);
    chk("combined cycles", 8'h01, 8'(fpsq_cpu_model_i.got_q.size()));
    exp_q = {NOP_OPCODE};
    chk_bytes("combined byte");
    step(2 * DEB);
    // Single deposit: length of the debounce interval and of the write pulse.
    func_req <= 5'h04;
    wait_sig(0, 1'b0, 10);
    n = 0;
    w = 0;
    while (ss_n === 1'b0 && n < 2 * DEB) begin
      step(1);
      if (n == 2) func_req <= 5'h00;
      #1;
      n++;
      w += (mwrite === 1'b1);
      if (mwrite === 1'b1 && w == 1) chk("deposit data", panel_sw[7:0], data_out);
    end
    chk("deposit length in range", 8'h01, 8'(n >= DEB - 3 && n <= DEB + 3));
    chk("mwrite width", 8'(MWR), 8'(w));
    step(2 * DEB);
    // Repeat with a held switch, then repeated deposit from one pulse.
    for (m = 0; m < 2; m++) begin
      step(1);
      repeat_function_mode  <= (m == 0);
      repeated_deposit_mode <= (m == 1);
      func_req <= 5'h04;
      w = 0;
      last_mw = 1'b0;
      for (k = 0; k < 4 * DEB; k++) begin
        step(1);
        if (k == 4 && m == 1) func_req <= 5'h00;
        #1;
        w += (mwrite === 1'b1 && last_mw === 1'b0);
        last_mw = mwrite;
      end
      chk("deposits per window in range", 8'h01, 8'(w >= 3 && w <= 5));
      step(1);
      repeat_function_mode  <= 1'b0;
      repeated_deposit_mode <= 1'b0;
      func_req <= 5'h00;
      step(2 * DEB);
    end
    // Bus-valid flag for both sample edges.
    tb_own <= 1'b1;
    for (m = 0; m < 3; m++) begin
      step(1);
      bv_clk_falling <= (m == 2);
      bv_use_clipped <= (m != 0);
      bv_clip_end    <= (m == 2);
      pwr_n <= 1'b0;
      wait_sig(4, 1'b1, 8);
      chk("bus-valid out at start", {7'h00, m != 1}, {7'h00, bus_valid_out});
      look(8);
      chk("bus-valid out held", {7'h00, m != 2}, {7'h00, bus_valid_out});
      step(1);
      pwr_n <= 1'b1;
      wait_sig(4, 1'b0, 8);
      step(1);
      tb_dbin <= 1'b1;
      look(20);
      chk("flag without ready", 8'h00, {7'h00, bus_valid_flag});
      step(1);
      prdy <= 1'b1;
      wait_sig(4, 1'b1, 16);
      step(1);
      tb_dbin <= 1'b0;
      prdy    <= 1'b0;
      wait_sig(4, 1'b0, 8);
    end
    // Output port at address FF, then a write without output status.
    step(1);
    addr   <= 16'h12FF;
    sout   <= 1'b1;
    tb_bus <= 8'hA5;
    pwr_n  <= 1'b0;
    step(4);
    pwr_n <= 1'b1;
    step(3);
    tb_bus <= 8'h5A;
    look(4);
    chk("port out", 8'hA5, out_port);
    step(1);
    sout  <= 1'b0;
    pwr_n <= 1'b0;
    step(4);
    pwr_n <= 1'b1;
    look(6);
    chk("port out without status", 8'hA5, out_port);
    // Input port at address FF, then a neighbouring address.
    step(1);
    sinp    <= 1'b1;
    tb_dbin <= 1'b1;
    look(6);
    chk("port in data", panel_sw[15:8], data_out);
    chk("port in oe_n", 8'h00, {7'h00, data_oe_n});
    step(1);
    addr <= 16'h12FE;
    look(6);
    chk("port in other address oe_n", 8'h01, {7'h00, data_oe_n});
    // Breakpoints while running: live external, live address, then latched.
    step(1);
    sinp      <= 1'b0;
    tb_dbin   <= 1'b0;
    stop_mode <= 1'b0;
    run_mode  <= 1'b1;
    wait_sig(1, 1'b1, 10);
    step(1);
    bp_select <= 4'h8;
    bp_enable <= 1'b1;
    bp_ext    <= 1'b1;
    wait_sig(1, 1'b0, 8);
    step(1);
    bp_ext <= 1'b0;
    wait_sig(1, 1'b1, 8);
    step(1);
    bp_select <= 4'h1;
    addr      <= panel_sw;
    wait_sig(1, 1'b0, 8);
    step(1);
    addr <= 16'h0000;
    wait_sig(1, 1'b1, 8);
    step(1);
    bp_select  <= 4'h8;
    bp_latched <= 1'b1;
    bp_ext     <= 1'b1;
    step(3);
    bp_ext <= 1'b0;
    look(20);
    chk("latched stop xrdy", 8'h00, {7'h00, xrdy});
    step(1);
    bp_enable <= 1'b0;
    wait_sig(1, 1'b1, 8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
